// *** common/prl_pkg.sv ***
// Shared constants for the power-on sequencer and register access lock.
// Assumes a 100 MHz device clock and a 6-bit register address space.
package prl_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS          = 10;
   localparam int POR_RELEASE_TIME_NS    = 40000;
   localparam int POR_ANALOG_DELAY_NS    = 5000;
   localparam int POR_OUTPUT_DELAY_NS    = POR_RELEASE_TIME_NS + POR_ANALOG_DELAY_NS;
   localparam int UNLOCK_WINDOW_TIME_NS  = 8000000;
   // Least times round up, the window (a longest time) rounds down.
   localparam int POR_RELEASE_CYC  = (POR_RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_ANALOG_CYC   = (POR_ANALOG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_OUTPUT_DELAY_CYC = POR_RELEASE_CYC + POR_ANALOG_CYC;
   localparam int UNLOCK_WINDOW_CYC_DEF = UNLOCK_WINDOW_TIME_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int         MEM_DEPTH          = 16;
   localparam logic [5:0] ADDR_FINE_GAIN     = 6'h00;
   localparam logic [5:0] ADDR_OFFSET_TRIM   = 6'h01;
   localparam logic [5:0] ADDR_COARSE_GAIN   = 6'h02;
   localparam logic [5:0] ADDR_LOCK_CFG      = 6'h03;
   localparam logic [5:0] ADDR_UNLOCK_KEY    = 6'h24;
   localparam int         TRIM_W             = 9;
   localparam int         COARSE_W           = 2;
   localparam int         PERM_LOCK_BIT      = 0;
   localparam logic [23:0] REG_RESET         = 24'h000000;
   // Arbitrary neutral customer key, not tied to any real part.
   localparam logic [29:0] CUSTOMER_KEY_DEF  = 30'h15A5_C3C3;
   localparam logic [1:0] RD_ECC_PASS        = 2'h3;
   localparam logic [3:0] RD_DONT_CARE       = 4'h0;

   // ------------------------------------------------------------------
   // Power sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_OFF     = 4'h1,
      ST_RELEASE = 4'h2,
      ST_ANALOG  = 4'h4,
      ST_RUN     = 4'h8
   } prl_state_e;

endpackage

// *** common/prl_timer_if.sv ***
// Start and expiry handshake between the sequencer and one interval timer.
// Assumes both ends share the device clock.
interface prl_timer_if;
   logic run;
   logic done;
   modport ctrl (output run, input done);
   modport tmr  (input run, output done);
endinterface

// *** rtl/prl_timer.sv ***
// Interval timer: counts while run is high, clears when it drops.
// Assumes run is synchronous to sys_clk_i.
module prl_timer #(
   parameter int LIMIT = 4
) (
   // Clock and reset
   input  wire logic  sys_clk_i,
   input  wire logic  rstn_i,
   // Control handshake
   prl_timer_if.tmr   t
);
   localparam int W = $clog2(LIMIT + 1);
   localparam logic [W-1:0] LIM = W'(LIMIT);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         done;
   } prl_tmr_s;

   prl_tmr_s q;
   prl_tmr_s d;

   // --------------------------------------------------------------
   // Counter
   // --------------------------------------------------------------
   // Saturates at the limit; done is high once LIMIT edges have passed.
   always_comb begin
      d = q;
      if (!t.run) begin
         d.cnt = '0;
      end else if (q.cnt != LIM) begin
         d.cnt = q.cnt + W'(1);
      end
      d.done = t.run && (d.cnt == LIM);
   end

   // State register.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign t.done = q.done;

   chk_timer_done_count: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      q.done |-> (q.cnt == LIM) && $past(t.run))
      else $error("timer done without reaching its limit");

endmodule

// *** rtl/prl_por_lock.sv ***
// Power-on sequencer and register access lock of the field sensor.
// Assumes supply comparators and the decoded programming command arrive
// synchronous to sys_clk_i; rstn_i is the supply-level power-on reset.
module prl_por_lock
   import prl_pkg::*;
#(
   parameter int          UNLOCK_WINDOW_CYC = prl_pkg::UNLOCK_WINDOW_CYC_DEF,
   parameter logic [29:0] CUSTOMER_KEY      = prl_pkg::CUSTOMER_KEY_DEF
) (
   // Clock and reset
   input  wire logic                          sys_clk_i,
   input  wire logic                          rstn_i,
   // Supply and ground monitors
   input  wire logic                          vcc_above_rise_i,
   input  wire logic                          vcc_below_fall_i,
   input  wire logic                          gnd_ok_i,
   // Decoded programming command
   input  wire logic                          cmd_valid_i,
   input  wire logic                          cmd_write_i,
   input  wire logic [5:0]                    cmd_addr_i,
   input  wire logic [29:0]                   cmd_data_i,
   // Read answer
   output logic                               rd_valid_o,
   output logic [29:0]                        rd_data_o,
   // Sensor output stage and trims
   output logic                               out_en_o,
   output logic                               logic_active_o,
   output logic [prl_pkg::TRIM_W-1:0]         fine_gain_o,
   output logic [prl_pkg::TRIM_W-1:0]         zero_field_offset_trim_o,
   output logic [prl_pkg::COARSE_W-1:0]       coarse_gain_o,
   // Lock status
   output logic                               access_locked_o,
   output logic                               permanent_write_lock_o
);
   import prl_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      prl_state_e                   state;
      logic                         active;
      logic                         locked;
      logic                         perm_lock;
      logic                         out_en;
      logic                         rd_valid;
      logic [29:0]                  rd_data;
      logic [MEM_DEPTH-1:0][23:0]   mem;
   } prl_top_s;

   prl_top_s q;
   prl_top_s d;

   prl_timer_if rel_if ();
   prl_timer_if ana_if ();
   prl_timer_if win_if ();

   logic        in_mem;
   logic [3:0]  idx;
   logic        wr_ok;
   logic        key_ok;

   // ------------------------------------------------------------------
   // Timers
   // ------------------------------------------------------------------
   // Release and analog delays run only in their own state; the unlock
   // window runs from reset release while the logic is active.
   assign rel_if.run = (q.state == ST_RELEASE);
   assign ana_if.run = (q.state == ST_ANALOG);
   assign win_if.run = q.active;

   prl_timer #(.LIMIT(POR_RELEASE_CYC)) u_rel_tmr (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .t         (rel_if.tmr)
   );

   prl_timer #(.LIMIT(POR_ANALOG_CYC)) u_ana_tmr (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .t         (ana_if.tmr)
   );

   prl_timer #(.LIMIT(UNLOCK_WINDOW_CYC)) u_win_tmr (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .t         (win_if.tmr)
   );

   // ------------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------------
   // A register write other than the unlock key is taken only with the logic out of reset, the access lock
   // open and no permanent write lock in force.
   assign in_mem = (cmd_addr_i < 6'(MEM_DEPTH));
   assign idx    = cmd_addr_i[3:0];
   assign wr_ok  = q.active && !q.locked && !q.perm_lock;
   assign key_ok = q.active && q.locked && !q.perm_lock && !win_if.done
                   && (cmd_data_i == CUSTOMER_KEY);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      d          = q;
      d.rd_valid = 1'b0;
      case (q.state)
         ST_OFF: begin
            if (vcc_above_rise_i && !vcc_below_fall_i) begin
               d.state = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            if (!vcc_above_rise_i || vcc_below_fall_i) begin
               d.state = ST_OFF;
            end else if (rel_if.done) begin
               d.state = ST_ANALOG;
            end
         end
         ST_ANALOG: begin
            if (vcc_below_fall_i) begin
               d.state = ST_OFF;
            end else if (ana_if.done) begin
               d.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (vcc_below_fall_i) begin
               d.state = ST_OFF;
            end
         end
         default: begin
            d.state = ST_OFF;
         end
      endcase

      // Logic leaves reset with the release count; the permanent lock is
      // sampled only here, so a newly set bit waits for a power cycle.
      if (q.state == ST_RELEASE && d.state == ST_ANALOG) begin
         d.active    = 1'b1;
         d.perm_lock = q.mem[ADDR_LOCK_CFG[3:0]][PERM_LOCK_BIT];
      end

      // Register access, rejected while locked except for the unlock key write.
      if (cmd_valid_i && q.active) begin
         if (cmd_write_i) begin
            if (cmd_addr_i == ADDR_UNLOCK_KEY) begin
               if (key_ok) begin
                  d.locked = 1'b0;
               end
            end else if (wr_ok && in_mem) begin
               d.mem[idx] = cmd_data_i[23:0];
            end
         end else if (!q.locked) begin
            d.rd_valid = 1'b1;
            d.rd_data  = {RD_DONT_CARE, RD_ECC_PASS, REG_RESET};
            if (in_mem) begin
               d.rd_data[23:0] = q.mem[idx];
            end
         end
      end

      // A supply fall re-arms the lock, even over a key taken in the same cycle.
      if (d.state == ST_OFF) begin
         d.active    = 1'b0;
         d.locked    = 1'b1;
         d.perm_lock = 1'b0;
      end

      // Output drives only in normal operation with ground present.
      d.out_en = (d.state == ST_RUN) && gnd_ok_i;
   end

   // State register.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q.state     <= ST_OFF;
         q.active    <= 1'b0;
         q.locked    <= 1'b1;
         q.perm_lock <= 1'b0;
         q.out_en    <= 1'b0;
         q.rd_valid  <= 1'b0;
         q.rd_data   <= '0;
         q.mem       <= {MEM_DEPTH{REG_RESET}};
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Trims steer the analog path directly from the stored words.
   assign rd_valid_o               = q.rd_valid;
   assign rd_data_o                = q.rd_data;
   assign out_en_o                 = q.out_en;
   assign logic_active_o           = q.active;
   assign fine_gain_o              = q.mem[ADDR_FINE_GAIN[3:0]][TRIM_W-1:0];
   assign zero_field_offset_trim_o = q.mem[ADDR_OFFSET_TRIM[3:0]][TRIM_W-1:0];
   assign coarse_gain_o            = q.mem[ADDR_COARSE_GAIN[3:0]][COARSE_W-1:0];
   assign access_locked_o          = q.locked;
   assign permanent_write_lock_o   = q.perm_lock;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   // Cycles since the sequencer last left the off state, saturating at POR_OUTPUT_DELAY_CYC + 8.
   int up_cnt;
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         up_cnt <= 0;
      end else if (q.state == ST_OFF) begin
         up_cnt <= 0;
      end else if (up_cnt < POR_OUTPUT_DELAY_CYC + 8) begin
         up_cnt <= up_cnt + 1;
      end
   end

   sequence s_good_key;
      cmd_valid_i && cmd_write_i && cmd_addr_i == ADDR_UNLOCK_KEY
      && cmd_data_i == CUSTOMER_KEY && q.active && !win_if.done && !q.perm_lock
      && !vcc_below_fall_i;
   endsequence

   chk_off_hiz: assert property ((q.state == ST_OFF) |-> !out_en_o && !logic_active_o)
      else $error("output driven while sequencer off");
   chk_fall_rearm: assert property (vcc_below_fall_i |=> !out_en_o && access_locked_o)
      else $error("supply fall did not float output and re-arm lock");
   chk_out_delay: assert property ($rose(out_en_o) |-> up_cnt >= POR_OUTPUT_DELAY_CYC)
      else $error("output enabled before full output delay");
   chk_rise_kept: assert property ((q.state == ST_RELEASE) && !vcc_above_rise_i
      |=> q.state == ST_OFF)
      else $error("release count kept after supply dropped");
   chk_locked_read: assert property (access_locked_o && cmd_valid_i && !cmd_write_i
      |=> !rd_valid_o)
      else $error("read answered while access locked");
   chk_unlock_key: assert property (s_good_key |=> !access_locked_o)
      else $error("valid key in window did not unlock");
   chk_late_key: assert property (access_locked_o && win_if.done && !vcc_below_fall_i
      |=> access_locked_o)
      else $error("lock cleared after window closed");
   chk_perm_write: assert property (permanent_write_lock_o && cmd_valid_i && cmd_write_i
      |=> $stable(fine_gain_o) && $stable(zero_field_offset_trim_o))
      else $error("register written under permanent lock");
   chk_perm_locked: assert property (permanent_write_lock_o |-> access_locked_o)
      else $error("access unlocked under permanent lock");
   chk_perm_sticky: assert property (permanent_write_lock_o && !vcc_below_fall_i
      |=> permanent_write_lock_o)
      else $error("permanent lock cleared without power cycle");
   chk_gnd_loss: assert property (!gnd_ok_i |=> !out_en_o ##1 (out_en_o || !gnd_ok_i
      || q.state != ST_RUN || $past(q.state) != ST_RUN || !$past(gnd_ok_i)))
      else $error("output not floated on ground loss");
   chk_no_spont_read: assert property (rd_valid_o |-> $past(cmd_valid_i) && !$past(cmd_write_i))
      else $error("read answer without a read command");

   // Power sequencing: the logic leaves reset only on the release count
   // and stays in normal operation until the supply falls.
   chk_active_release: assert property ($rose(logic_active_o) |-> $past(rel_if.done))
      else $error("logic released before the release count");
   chk_run_hold: assert property ((q.state == ST_RUN) && !vcc_below_fall_i
      |=> q.state == ST_RUN)
      else $error("normal operation left without a supply fall");
   chk_dip_restart: assert property ($fell(logic_active_o) |-> q.state == ST_OFF)
      else $error("logic reset without restarting the sequence");
   chk_off_rearm: assert property ((q.state == ST_OFF) |-> access_locked_o
      && !permanent_write_lock_o)
      else $error("lock not re-armed while sequencer off");

   // Register access: an open lock answers reads, a wrong key never opens it.
   sequence s_open_read;
      cmd_valid_i && !cmd_write_i && q.active && !access_locked_o;
   endsequence

   sequence s_wrong_key;
      cmd_valid_i && cmd_write_i && cmd_addr_i == ADDR_UNLOCK_KEY
      && cmd_data_i != CUSTOMER_KEY;
   endsequence

   chk_read_answer: assert property (s_open_read |=> rd_valid_o)
      else $error("read with open lock not answered");
   chk_wrong_key: assert property (access_locked_o ##0 s_wrong_key |=> access_locked_o)
      else $error("wrong key cleared the lock");

endmodule

// *** dv/prl_ctrl_model.sv ***
// Programming controller model: drives the supply monitors and decoded commands.
// Assumes its tasks are called at a falling edge of sys_clk_i.
module prl_ctrl_model (
   // Clock
   input  wire logic  sys_clk_i,
   // Supply drive
   output logic       vcc_above_rise_o,
   output logic       vcc_below_fall_o,
   // Command drive
   output logic       cmd_valid_o,
   output logic       cmd_write_o,
   output logic [5:0] cmd_addr_o,
   output logic [29:0] cmd_data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Supply starts off, below the falling threshold.
   initial begin
      vcc_above_rise_o = 1'h0;
      vcc_below_fall_o = 1'h1;
      cmd_valid_o = 1'h0;
      cmd_write_o = 1'h0;
      cmd_addr_o = 6'h00;
      cmd_data_o = 30'h0000_0000;
   end

   // Sets both supply comparator levels.
   task automatic supply(input logic rise, input logic fall);
      vcc_above_rise_o = rise;
      vcc_below_fall_o = fall;
   endtask

   // One decoded frame, always started here and never by the device.
   task automatic send(input logic wr, input logic [5:0] addr, input logic [29:0] data);
      cmd_valid_o = 1'h1;
      cmd_write_o = wr;
      cmd_addr_o = addr;
      cmd_data_o = data;
      @(negedge sys_clk_i);
      // Address and data are scrambled once the frame ends so stale values never help.
      cmd_valid_o = 1'h0;
      cmd_addr_o = ~addr;
      cmd_data_o = ~data;
   endtask
endmodule

// *** dv/prl_por_lock_tb.sv ***
// Self-checking bench for the power-on sequencer and access lock.
// Assumes the controller model drives supply and commands at falling edges.
module prl_por_lock_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import prl_pkg::*;

   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   localparam int WIN = 1000;
   localparam int REL = POR_RELEASE_CYC;
   localparam int ANA = POR_ANALOG_CYC;
   localparam logic [29:0] KEY = CUSTOMER_KEY_DEF;
   logic sys_clk_i, rstn_i, gnd_ok_i, rise, fall, cv, cw;
   logic [5:0] ca;
   logic [29:0] cd, rd_data_o;
   logic rd_valid_o, out_en_o, logic_active_o, access_locked_o, permanent_write_lock_o;
   logic [TRIM_W-1:0] fine_gain_o, zero_field_offset_trim_o;
   logic [COARSE_W-1:0] coarse_gain_o;
   int failures = 0;
   int checks_done = 0;

   prl_por_lock #(.UNLOCK_WINDOW_CYC(WIN)) prl_por_lock_inst (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .vcc_above_rise_i(rise),
      .vcc_below_fall_i(fall), .gnd_ok_i(gnd_ok_i), .cmd_valid_i(cv), .cmd_write_i(cw),
      .cmd_addr_i(ca), .cmd_data_i(cd), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
      .out_en_o(out_en_o), .logic_active_o(logic_active_o), .fine_gain_o(fine_gain_o),
      .zero_field_offset_trim_o(zero_field_offset_trim_o), .coarse_gain_o(coarse_gain_o),
      .access_locked_o(access_locked_o), .permanent_write_lock_o(permanent_write_lock_o));

   prl_ctrl_model prl_ctrl_model_inst (
      .sys_clk_i(sys_clk_i), .vcc_above_rise_o(rise), .vcc_below_fall_o(fall),
      .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_addr_o(ca), .cmd_data_o(cd));

   // Free-running 100 MHz clock.
   initial sys_clk_i = 1'h0;
   always #5 sys_clk_i = ~sys_clk_i;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Compares a value with case equality.
   task automatic check_val(input logic [29:0] got, input logic [29:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Compares a measured cycle count with a range.
   task automatic check_cnt(input int got, input int lo, input int hi, input string what);
      checks_done++;
      if (got < lo || got > hi) begin
         failures++;
         $display("Error at %0t: %s took %0d cycles", $time, what, got);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask

   // Waits, bounded, for the logic release (sel 0) or the output enable (sel 1).
   task automatic wait_hi(input bit sel, input int max, inout int cnt);
      logic s;
      s = 1'h0;
      while (s !== 1'h1) begin
         @(negedge sys_clk_i);
         cnt++;
         s = sel ? out_en_o : logic_active_o;
         if (cnt > max) begin
            failures++;
            $display("Error at %0t: wait for release timed out", $time);
            print_verdict();
         end
      end
   endtask

   // Raises the supply and measures the release time.
   task automatic power_on(output int cnt);
      cnt = 0;
      prl_ctrl_model_inst.supply(1'h1, 1'h0);
      wait_hi(1'h0, REL + 10, cnt);
      check_cnt(cnt, REL + 2, REL + 2, "logic release");
   endtask

   // Drops the supply to the falling threshold.
   task automatic power_off();
      prl_ctrl_model_inst.supply(1'h0, 1'h1);
      cycles(1);
      check_val({28'h0, logic_active_o, out_en_o}, 30'h0, "reset on dip");
      check_val({29'h0, access_locked_o}, 30'h1, "lock re-armed");
      cycles(2);
   endtask

   task automatic wr(input logic [5:0] a, input logic [29:0] d);
      prl_ctrl_model_inst.send(1'h1, a, d);
      cycles(1);
   endtask

   // The answer stands for one cycle only, so it is looked at as the frame ends.
   task automatic rd(input logic [5:0] a, input logic v, input logic [23:0] d);
      prl_ctrl_model_inst.send(1'h0, a, 30'h0);
      check_val({29'h0, rd_valid_o}, {29'h0, v}, "read answer");
      if (v) check_val(rd_data_o, {RD_DONT_CARE, RD_ECC_PASS, d}, "read data");
      cycles(1);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset();
      check_val({28'h0, out_en_o, logic_active_o}, 30'h0, "output in reset");
      check_val({29'h0, access_locked_o}, 30'h1, "lock in reset");
      check_val({29'h0, rd_valid_o}, 30'h0, "no answer in reset");
      $display("test reset done");
   endtask

   // Interrupted count restarts; output delay; ground loss; wrong key.
   task automatic test_power();
      int cnt;
      prl_ctrl_model_inst.supply(1'h1, 1'h0);
      cycles(2000);
      prl_ctrl_model_inst.supply(1'h0, 1'h0);
      cycles(1);
      check_val({28'h0, out_en_o, logic_active_o}, 30'h0, "early release");
      power_on(cnt);
      wait_hi(1'h1, REL + ANA + 10, cnt);
      check_cnt(cnt, REL + ANA + 3, REL + ANA + 4, "output delay");
      gnd_ok_i = 1'h0;
      cycles(1);
      check_val({29'h0, out_en_o}, 30'h0, "ground lost");
      gnd_ok_i = 1'h1;
      cycles(2);
      check_val({29'h0, out_en_o}, 30'h1, "ground back");
      wr(ADDR_UNLOCK_KEY, KEY ^ 30'h0000_0001);
      check_val({29'h0, access_locked_o}, 30'h1, "wrong key");
      power_off();
      $display("test power done");
   endtask

   task automatic test_window();
      int cnt;
      power_on(cnt);
      cycles(WIN + 10);
      wr(ADDR_UNLOCK_KEY, KEY);
      check_val({29'h0, access_locked_o}, 30'h1, "late key");
      power_off();
      $display("test window done");
   endtask

   task automatic test_unlock();
      int cnt;
      power_on(cnt);
      rd(ADDR_FINE_GAIN, 1'h0, 24'h0);
      wr(ADDR_FINE_GAIN, 30'h0000_01A5);
      check_val({21'h0, fine_gain_o}, 30'h0, "locked write");
      wr(ADDR_UNLOCK_KEY, KEY);
      check_val({29'h0, access_locked_o}, 30'h0, "key accepted");
      wr(ADDR_FINE_GAIN, 30'h3F00_01A5);
      wr(ADDR_OFFSET_TRIM, 30'h0000_00C3);
      check_val({21'h0, fine_gain_o}, 30'h1A5, "fine gain");
      check_val({21'h0, zero_field_offset_trim_o}, 30'hC3, "offset trim");
      check_val({28'h0, coarse_gain_o}, 30'h0, "coarse untouched");
      rd(ADDR_FINE_GAIN, 1'h1, 24'h0001A5);
      rd(6'h30, 1'h1, 24'h0);
      rd(ADDR_UNLOCK_KEY, 1'h1, 24'h0);
      wr(ADDR_LOCK_CFG, 30'h0000_0001);
      check_val({29'h0, permanent_write_lock_o}, 30'h0, "lock before cycle");
      power_off();
      $display("test unlock done");
   endtask

   task automatic test_perm();
      int cnt;
      power_on(cnt);
      check_val({29'h0, permanent_write_lock_o}, 30'h1, "permanent lock");
      wr(ADDR_UNLOCK_KEY, KEY);
      check_val({29'h0, access_locked_o}, 30'h1, "key ignored");
      wr(ADDR_LOCK_CFG, 30'h0000_0000);
      wr(ADDR_FINE_GAIN, 30'h0000_0000);
      check_val({21'h0, fine_gain_o}, 30'h1A5, "write refused");
      power_off();
      power_on(cnt);
      check_val({29'h0, permanent_write_lock_o}, 30'h1, "lock kept");
      power_off();
      $display("test perm done");
   endtask

   // Main sequence.
   initial begin
      rstn_i = 1'h0;
      gnd_ok_i = 1'h1;
      cycles(20);
      test_reset();
      rstn_i = 1'h1;
      cycles(2);
      test_power();
      test_window();
      test_unlock();
      test_perm();
      print_verdict();
   end
endmodule
